// ### verilog/tsp_gate.sv
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
module tsp_gate
  import tsp_pkg::*;
#(
  parameter int TB_HALF = TB_HALF_CYC,
  parameter bit VARIANT_80K = 1'b0
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Asynchronous sense pins.
  input wire logic osc_320k,
  input wire logic unregulated_bias,
  input wire logic ovp_ok,
  input wire logic thermal_ok,
  input wire logic reg_ok,
  input wire logic bias_ok,
  input wire logic voltage_loop_low,
  input wire logic protect_latch_clear_n,
  // Power stage and sequencer outputs.
  output logic pwm_on,
  output logic pwm_off,
  output logic down_prog_req,
  output logic relay_drive_n,
  output logic line_loss_flag,
  output logic timebase_out,
  output logic relay_stage,
  output logic mg_stage,
  output logic mid_stage,
  output logic mid_clk,
  output logic mod_clk,
  output logic irq,
  // AXI4-Lite slave.
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);

  localparam int TB_W = $clog2(TB_HALF + 1);
  // Synchroniser flops start at the idle pin levels, so reset release never looks like a trip.
  localparam logic [PIN_N-1:0] SYNC_IDLE = PIN_N'((1 << PIN_OVP) | (1 << PIN_THERM) | (1 << PIN_REG)
                                               | (1 << PIN_BOK) | (1 << PIN_CLR));

  // A zero half period would leave the timebase frozen, so it is refused when elaborating.
  if (TB_HALF < 1)
  begin
    $error("TB_HALF must be at least one cycle");
  end

  typedef struct packed {
    logic [PIN_N-1:0] sync1;
    logic [PIN_N-1:0] sync2;
    logic osc_d;
    logic [DIV_W-1:0] div;
    logic [TB_W-1:0] tb_cnt;
    logic [TICK_W-1:0] ticks;
    logic [7:0] on_cnt;
    logic [9:0] off_cnt;
    logic on_pulse;
    logic off_pulse;
    logic ovp_latched;
    logic down_req;
    logic relay_n;
    logic mains_good;
    logic tb_out;
    logic relay_st;
    logic mg_st;
    logic mid_st;
    logic bias_d;
    logic ctrl_en;
    logic [IRQ_N-1:0] irq_stat;
    logic [IRQ_N-1:0] irq_mask;
    logic irq;
    logic awready;
    logic wready;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tsp_state_t;

  tsp_state_t st_r;
  tsp_state_t st_nxt;

  // Pulse train decode: high for each odd-free slot of the train.
  function automatic logic train(input logic [TICK_W-1:0] t, input logic [TICK_W-1:0] w, input int n);
    logic [TICK_W-1:0] slot;
    slot = t / w;
    return (32'(slot) < 2 * n) && !slot[0];
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic bias_s;
  logic gate_ok;
  logic rise20;
  logic fall20;
  logic osc_rise;
  logic [DIV_W-1:0] div_n;
  logic aw_take;
  logic w_take;
  logic [IRQ_N-1:0] ev;

  // Gate terms are computed once here so the assertions see the same values.
  always_comb
  begin
    st_nxt = st_r;
    bias_s = st_r.sync2[PIN_BIAS];
    // Seven gating inputs plus the software enable.
    gate_ok = st_r.mains_good & st_r.sync2[PIN_OVP] & st_r.sync2[PIN_THERM] & ~st_r.off_pulse
            & ~st_r.ovp_latched & st_r.sync2[PIN_REG] & st_r.sync2[PIN_BOK] & st_r.ctrl_en;
    st_nxt.sync1 = {protect_latch_clear_n, voltage_loop_low, bias_ok, reg_ok, ovp_ok, thermal_ok,
                    unregulated_bias, osc_320k};
    st_nxt.sync1[PIN_OVP] = ovp_ok;
    st_nxt.sync1[PIN_THERM] = thermal_ok;
    st_nxt.sync2 = st_r.sync1;
    // Divide the oscillator down to the intermediate and modulator clocks.
    st_nxt.osc_d = st_r.sync2[PIN_OSC];
    osc_rise = st_r.sync2[PIN_OSC] & ~st_r.osc_d;
    div_n = osc_rise ? st_r.div + 1'b1 : st_r.div;
    st_nxt.div = div_n;
    rise20 = div_n[TAP_20K] & ~st_r.div[TAP_20K];
    fall20 = ~div_n[TAP_20K] & st_r.div[TAP_20K];
    // Sequencer timebase; a bias loss restarts everything from zero.
    st_nxt.bias_d = bias_s;
    if (!bias_s)
    begin
      st_nxt.tb_cnt = '0;
      st_nxt.ticks = '0;
      st_nxt.tb_out = 1'b0;
    end
    else if (st_r.ticks < MG_TICKS)
    begin
      // Burst runs only until mains-good time, then the square wave stops.
      if (st_r.tb_cnt == TB_W'(TB_HALF - 1))
      begin
        st_nxt.tb_cnt = '0;
        st_nxt.tb_out = ~st_r.tb_out;
        if (st_r.tb_out)
        begin
          st_nxt.ticks = st_r.ticks + 1'b1;
        end
      end
      else
      begin
        st_nxt.tb_cnt = st_r.tb_cnt + 1'b1;
      end
    end
    else
    begin
      st_nxt.tb_out = 1'b0;
    end
    st_nxt.relay_n = ~(bias_s && st_nxt.ticks >= RELAY_TICKS);
    st_nxt.mains_good = bias_s && st_nxt.ticks >= MG_TICKS;
    st_nxt.mid_st = bias_s && st_nxt.ticks >= MID_TICKS;
    st_nxt.relay_st = bias_s && (train(st_nxt.ticks, RELAY_PULSE_TICKS, RELAY_PULSE_COUNT)
                      || st_nxt.ticks >= RELAY_TICKS);
    st_nxt.mg_st = bias_s && (train(st_nxt.ticks, MG_PULSE_TICKS, MG_PULSE_COUNT)
                   || st_nxt.ticks >= MG_TICKS);
    // On pulse: started only at a 20 kHz edge with all gates high.
    if (st_r.on_pulse)
    begin
      if (!gate_ok || st_r.on_cnt == 8'(ON_PULSE_CYC - 1))
      begin
        st_nxt.on_pulse = 1'b0;
        st_nxt.on_cnt = '0;
      end
      else
      begin
        st_nxt.on_cnt = st_r.on_cnt + 1'b1;
      end
    end
    else if (rise20 && gate_ok)
    begin
      st_nxt.on_pulse = 1'b1;
      st_nxt.on_cnt = '0;
    end
    // Off pulse mid-period on its own channel, so it never overlaps a start.
    if (st_r.off_pulse)
    begin
      if (st_r.off_cnt == 10'(OFF_PULSE_CYC - 1))
      begin
        st_nxt.off_pulse = 1'b0;
        st_nxt.off_cnt = '0;
      end
      else
      begin
        st_nxt.off_cnt = st_r.off_cnt + 1'b1;
      end
    end
    else if (fall20)
    begin
      st_nxt.off_pulse = 1'b1;
      st_nxt.off_cnt = '0;
    end
    st_nxt.down_req = st_nxt.off_pulse | st_r.sync2[PIN_VLL];
    // Trip sets the latch and wins over a simultaneous clear.
    if (!st_r.sync2[PIN_OVP])
    begin
      st_nxt.ovp_latched = 1'b1;
    end
    else if (!st_r.sync2[PIN_CLR])
    begin
      st_nxt.ovp_latched = 1'b0;
    end
    // Interrupt events.
    ev = '0;
    ev[IRQ_MG_UP] = st_nxt.mains_good & ~st_r.mains_good;
    ev[IRQ_OVP_TRIP] = st_nxt.ovp_latched & ~st_r.ovp_latched;
    ev[IRQ_CUT] = st_r.on_pulse & ~gate_ok;
    ev[IRQ_BIAS_LOST] = st_r.bias_d & ~bias_s;
    // AXI write: address and data taken in either order, then one response.
    aw_take = s_awvalid & st_r.awready;
    w_take = s_wvalid & st_r.wready;
    if (aw_take)
    begin
      st_nxt.awready = 1'b0;
      st_nxt.waddr = s_awaddr;
    end
    if (w_take)
    begin
      st_nxt.wready = 1'b0;
      st_nxt.wdata = s_wdata;
      st_nxt.wstrb = s_wstrb;
    end
    if (!st_r.awready && !st_r.wready && !st_r.bvalid)
    begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      unique case (st_r.waddr)
        REG_CTRL:
        begin
          if (st_r.wstrb[0])
          begin
            st_nxt.ctrl_en = st_r.wdata[0];
          end
        end
        REG_IRQ_STAT:
        begin
          if (st_r.wstrb[0])
          begin
            st_nxt.irq_stat = st_r.irq_stat & ~st_r.wdata[IRQ_N-1:0];
          end
        end
        REG_IRQ_MASK:
        begin
          if (st_r.wstrb[0])
          begin
            st_nxt.irq_mask = st_r.wdata[IRQ_N-1:0];
          end
        end
        REG_STATUS:
        begin
          st_nxt.bresp = RESP_OKAY;
        end
        default:
        begin
          st_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (st_r.bvalid && s_bready)
    begin
      st_nxt.bvalid = 1'b0;
      st_nxt.awready = 1'b1;
      st_nxt.wready = 1'b1;
    end
    // Hardware set wins over the write-one clear.
    st_nxt.irq_stat = st_nxt.irq_stat | ev;
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
    // AXI read: one-cycle answer, held until rready.
    if (s_arvalid && st_r.arready)
    begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      st_nxt.rdata = '0;
      unique case (s_araddr)
        REG_CTRL: st_nxt.rdata[0] = st_r.ctrl_en;
        REG_STATUS: st_nxt.rdata[10:0] = {gate_ok, st_r.ovp_latched, st_r.down_req, st_r.off_pulse,
                                          st_r.on_pulse, st_r.mid_st, st_r.mg_st, st_r.relay_st,
                                          st_r.mains_good, ~st_r.relay_n, bias_s};
        REG_IRQ_STAT: st_nxt.rdata[IRQ_N-1:0] = st_r.irq_stat;
        REG_IRQ_MASK: st_nxt.rdata[IRQ_N-1:0] = st_r.irq_mask;
        default: st_nxt.rresp = RESP_SLVERR;
      endcase
    end
    if (st_r.rvalid && s_rready)
    begin
      st_nxt.rvalid = 1'b0;
      st_nxt.arready = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset leaves the relay open and the modulator quiet.
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '0;
      st_r.relay_n <= 1'b1;
      st_r.sync1 <= SYNC_IDLE;
      st_r.sync2 <= SYNC_IDLE;
      st_r.ctrl_en <= CTRL_EN_RST;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs are straight flip-flop bits.
  assign pwm_on = st_r.on_pulse;
  assign pwm_off = st_r.off_pulse;
  assign down_prog_req = st_r.down_req;
  assign relay_drive_n = st_r.relay_n;
  assign line_loss_flag = st_r.mains_good;
  assign timebase_out = st_r.tb_out;
  assign relay_stage = st_r.relay_st;
  assign mg_stage = st_r.mg_st;
  assign mid_stage = st_r.mid_st;
  assign mid_clk = VARIANT_80K ? st_r.div[TAP_80K] : st_r.div[TAP_40K];
  assign mod_clk = st_r.div[TAP_20K];
  assign irq = st_r.irq;
  assign s_awready = st_r.awready;
  assign s_wready = st_r.wready;
  assign s_bresp = st_r.bresp;
  assign s_bvalid = st_r.bvalid;
  assign s_arready = st_r.arready;
  assign s_rdata = st_r.rdata;
  assign s_rresp = st_r.rresp;
  assign s_rvalid = st_r.rvalid;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  chk_relay_close: assert property ($fell(st_r.relay_n) |-> st_r.ticks == RELAY_TICKS)
    else $error("relay closed at wrong time");
  chk_mains_good: assert property ($rose(st_r.mains_good) |-> st_r.ticks == MG_TICKS)
    else $error("mains-good rose at wrong time");
  chk_gate_enable: assert property ($rose(st_r.on_pulse) |-> $past(st_r.mains_good && st_r.sync2[PIN_OVP]
    && st_r.sync2[PIN_THERM]))
    else $error("pulse started without enables");
  chk_tb_stop: assert property (st_r.ticks >= MG_TICKS |=> !st_r.tb_out)
    else $error("timebase ran past burst");
  chk_mid_rise: assert property ($rose(st_r.mid_st) |-> st_r.ticks == MID_TICKS)
    else $error("intermediate stage rose at wrong time");
  chk_on_edge: assert property ($rose(st_r.on_pulse) |-> $past(rise20))
    else $error("pulse not started at clock edge");
  chk_on_cut: assert property (st_r.on_pulse && !gate_ok |=> !st_r.on_pulse)
    else $error("pulse not ended by gate");
  chk_no_start: assert property (!gate_ok && !st_r.on_pulse |=> !st_r.on_pulse)
    else $error("pulse started while inhibited");
  chk_on_width: assert property (st_r.on_pulse |-> 32'(st_r.on_cnt) < ON_PULSE_CYC)
    else $error("on pulse too long");
  chk_off_width: assert property ($fell(st_r.off_pulse) |-> $past(st_r.off_cnt) == 10'(OFF_PULSE_CYC - 1))
    else $error("off pulse wrong width");
  chk_down_req: assert property (st_r.off_pulse |-> st_r.down_req)
    else $error("no discharge on off pulse");
  chk_ovp_hold: assert property (st_r.ovp_latched && st_r.sync2[PIN_CLR] |=> st_r.ovp_latched)
    else $error("latch cleared without clear");
  chk_bias_restart: assert property (!st_r.sync2[PIN_BIAS] |=> st_r.ticks == '0 && st_r.relay_n
    && !st_r.mains_good)
    else $error("sequencer not restarted");

  cov_mains_up: cover property ($rose(st_r.mains_good));
  cov_pulse_cut: cover property (st_r.on_pulse && !gate_ok);
  cov_ovp_trip: cover property ($rose(st_r.ovp_latched));
  cov_full_pulse: cover property ($fell(st_r.on_pulse) && $past(st_r.on_cnt) == 8'(ON_PULSE_CYC - 1));

endmodule

// ### verilog/tsp_pkg.sv
package tsp_pkg;

  // ----------------------------------------------------------------
  // Clock and timing figures
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ON_PULSE_NS = 1700;
  localparam int OFF_PULSE_NS = 10000;
  localparam int ON_PULSE_CYC = ON_PULSE_NS / CLK_PERIOD_NS;
  localparam int OFF_PULSE_CYC = OFF_PULSE_NS / CLK_PERIOD_NS;
  localparam int TB_FREQ_HZ = 1250;
  localparam int TB_HALF_CYC = CLK_HZ / (2 * TB_FREQ_HZ);
  localparam int RELAY_MS = 2500;
  localparam int MAINS_GOOD_MS = 2900;
  localparam int MID_STAGE_MS = 1700;
  localparam int RELAY_PULSE_MS = 840;
  localparam int MG_PULSE_MS = 420;
  localparam int MG_PULSE_COUNT = 3;
  localparam int RELAY_PULSE_COUNT = 1;
  localparam int MS_PER_S = 1000;
  localparam int TICK_W = 12;
  localparam logic [TICK_W-1:0] RELAY_TICKS = TICK_W'(RELAY_MS * TB_FREQ_HZ / MS_PER_S);
  localparam logic [TICK_W-1:0] MG_TICKS = TICK_W'(MAINS_GOOD_MS * TB_FREQ_HZ / MS_PER_S);
  localparam logic [TICK_W-1:0] MID_TICKS = TICK_W'(MID_STAGE_MS * TB_FREQ_HZ / MS_PER_S);
  localparam logic [TICK_W-1:0] RELAY_PULSE_TICKS = TICK_W'(RELAY_PULSE_MS * TB_FREQ_HZ / MS_PER_S);
  localparam logic [TICK_W-1:0] MG_PULSE_TICKS = TICK_W'(MG_PULSE_MS * TB_FREQ_HZ / MS_PER_S);

  // ----------------------------------------------------------------
  // Oscillator divider taps: 320 kHz / 8 = 40 kHz, / 4 = 80 kHz, / 16 = 20 kHz
  // ----------------------------------------------------------------
  localparam int DIV_W = 4;
  localparam int TAP_40K = 2;
  localparam int TAP_80K = 1;
  localparam int TAP_20K = 3;

  // ----------------------------------------------------------------
  // Synchronised pin indices
  // ----------------------------------------------------------------
  localparam int PIN_N = 8;
  localparam int PIN_OSC = 0;
  localparam int PIN_BIAS = 1;
  localparam int PIN_OVP = 2;
  localparam int PIN_THERM = 3;
  localparam int PIN_REG = 4;
  localparam int PIN_BOK = 5;
  localparam int PIN_VLL = 6;
  localparam int PIN_CLR = 7;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'hC;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int IRQ_N = 4;
  localparam int IRQ_MG_UP = 0;
  localparam int IRQ_OVP_TRIP = 1;
  localparam int IRQ_CUT = 2;
  localparam int IRQ_BIAS_LOST = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### verif/tsp_partner.sv
module tsp_partner
(
  // Clock and watched power-stage pins.
  input wire logic core_clk,
  input wire logic pwm_on,
  input wire logic pwm_off,
  input wire logic mod_clk,
  // Oscillator source and pulse measurements.
  output logic osc_320k,
  output int on_w,
  output int off_w,
  output int on_cnt,
  output int late
);
  timeunit 1ns;
  timeprecision 100ps;
  int on_run;
  int off_run;
  int since;
  bit mod_q;

  // The source runs free, so the divider keeps ticking between bursts.
  initial
  begin
    osc_320k = 1'b0;
    forever #1562.5 osc_320k = ~osc_320k;
  end

  // Widths are latched as each pulse ends; a start far from a clock rise is counted as late.
  always @(posedge core_clk)
  begin
    on_run <= pwm_on ? on_run + 1 : 0;
    off_run <= pwm_off ? off_run + 1 : 0;
    mod_q <= mod_clk;
    since <= (mod_clk && !mod_q) ? 0 : since + 1;
    if (!pwm_on && on_run > 0)
      on_w <= on_run;
    if (!pwm_off && off_run > 0)
      off_w <= off_run;
    if (pwm_on && on_run == 0)
    begin
      on_cnt <= on_cnt + 1;
      late <= late + (((mod_clk && !mod_q) || since < 4) ? 0 : 1);
    end
  end
endmodule

// ### verif/tsp_gate_test.sv
module tsp_gate_test import tsp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // A short timebase keeps the turn-on run near 29000 cycles.
  localparam int HALF = 4;
  localparam int TICK = 2 * HALF;
  localparam int SLACK = TICK + 6;
  logic core_clk, resetn, osc_320k, unregulated_bias, ovp_ok, thermal_ok, reg_ok, bias_ok;
  logic voltage_loop_low, protect_latch_clear_n, pwm_on, pwm_off, down_prog_req, relay_drive_n;
  logic line_loss_flag, timebase_out, relay_stage, mg_stage, mid_stage, mid_clk, mod_clk, irq;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [3:0] s_awaddr, s_araddr, s_wstrb;
  logic [31:0] s_wdata, s_rdata, d;
  logic [1:0] s_bresp, s_rresp, r;
  int fail_count, num_checks, on_w, off_w, on_cnt, late, n_rel, n_mg, n_tb;
  int n_osc, n_mid, n_mod;
  bit rel_q, mg_q, tb_q, osc_q, mid_q, mod_q;

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  tsp_gate #(.TB_HALF(HALF), .VARIANT_80K(1'b0)) tsp_gate_inst (
    .core_clk(core_clk), .resetn(resetn), .osc_320k(osc_320k), .unregulated_bias(unregulated_bias),
    .ovp_ok(ovp_ok), .thermal_ok(thermal_ok), .reg_ok(reg_ok), .bias_ok(bias_ok),
    .voltage_loop_low(voltage_loop_low), .protect_latch_clear_n(protect_latch_clear_n),
    .pwm_on(pwm_on), .pwm_off(pwm_off), .down_prog_req(down_prog_req), .relay_drive_n(relay_drive_n),
    .line_loss_flag(line_loss_flag), .timebase_out(timebase_out), .relay_stage(relay_stage),
    .mg_stage(mg_stage), .mid_stage(mid_stage), .mid_clk(mid_clk), .mod_clk(mod_clk), .irq(irq),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));

  tsp_partner tsp_partner_inst (.core_clk(core_clk), .pwm_on(pwm_on), .pwm_off(pwm_off),
    .mod_clk(mod_clk), .osc_320k(osc_320k), .on_w(on_w), .off_w(off_w), .on_cnt(on_cnt), .late(late));

  // Reference edge counts of the sequencer stage outputs.
  always @(posedge core_clk)
  begin
    rel_q <= relay_stage;
    mg_q <= mg_stage;
    tb_q <= timebase_out;
    n_rel <= n_rel + int'(relay_stage && !rel_q);
    n_mg <= n_mg + int'(mg_stage && !mg_q);
    n_tb <= n_tb + int'(timebase_out != tb_q);
    // Divided clocks are counted against the source the partner drives.
    osc_q <= osc_320k;
    mid_q <= mid_clk;
    mod_q <= mod_clk;
    n_osc <= n_osc + int'(osc_320k && !osc_q);
    n_mid <= n_mid + int'(mid_clk && !mid_q);
    n_mod <= n_mod + int'(mod_clk && !mod_q);
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // A time may lag its figure by the input synchroniser and one tick, never lead it.
  task automatic check_time(input string name, input int exp, input int got);
    num_checks++;
    if (got < exp || got > exp + SLACK)
    begin
      fail_count++;
      $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic give_up(input string what);
    fail_count++;
    $display("MISMATCH %s expected done seen timeout", what);
    tally_and_finish();
  endtask

  task automatic tick_wait(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  task automatic wait_lvl(ref logic s, input logic v);
    repeat (6000)
    begin
      if (s === v)
        break;
      @(posedge core_clk);
    end
    if (s !== v)
      give_up("level");
  endtask

  // The extra edge at the end keeps back-to-back calls from driving bready twice at once.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    repeat (50)
    begin
      @(posedge core_clk);
      if (s_awready)
        s_awvalid <= 1'b0;
      if (s_wready)
        s_wvalid <= 1'b0;
      if (s_bvalid)
        break;
    end
    if (!s_bvalid)
      give_up("write");
    r = s_bresp;
    s_bready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic axi_rd(input logic [3:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    repeat (50)
    begin
      @(posedge core_clk);
      if (s_arready)
        s_arvalid <= 1'b0;
      if (s_rvalid)
        break;
    end
    if (!s_rvalid)
      give_up("read");
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wait_pulse();
    int c0;
    c0 = on_cnt;
    repeat (6000)
    begin
      @(posedge core_clk);
      if (on_cnt != c0)
        break;
    end
    if (on_cnt == c0)
      give_up("pulse");
  endtask

  task automatic set_gate(input int g, input logic v);
    case (g)
      0: thermal_ok <= v;
      1: reg_ok <= v;
      2: bias_ok <= v;
      3: ovp_ok <= v;
      default: axi_wr(REG_CTRL, {31'h0, v});
    endcase
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int c0;
    int t_mid;
    int t_rel;
    int t_mg;
    {resetn, unregulated_bias, voltage_loop_low, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {ovp_ok, thermal_ok, reg_ok, bias_ok, protect_latch_clear_n} = '1;
    s_awaddr = 4'h0;
    s_araddr = 4'h0;
    s_wdata = 32'h0;
    s_wstrb = 4'hF;
    t_mid = -1;
    t_rel = -1;
    t_mg = -1;
    void'($urandom(12906));
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    check("relay_drive_n", 1, relay_drive_n);
    check("mains_good", 0, line_loss_flag);
    axi_rd(REG_CTRL);
    check("ctrl", 1, d);
    axi_rd(4'h2);
    check("unmapped_resp", RESP_SLVERR, r);
    axi_wr(4'h6, 32'h1);
    check("unmapped_wr_resp", RESP_SLVERR, r);
    axi_wr(REG_IRQ_MASK, 32'h3);
    check("mask_resp", RESP_OKAY, r);
    $display("test reset done");
    unregulated_bias <= 1'b1;
    for (int n = 0; n < 31000 && !line_loss_flag; n++)
    begin
      @(posedge core_clk);
      if (mid_stage && t_mid < 0)
        t_mid = n;
      if (!relay_drive_n && t_rel < 0)
        t_rel = n;
      t_mg = n;
    end
    if (!line_loss_flag)
      give_up("mains_good");
    check_time("mid_stage", MID_STAGE_MS * TB_FREQ_HZ / MS_PER_S * TICK, t_mid);
    check_time("relay_drive", RELAY_MS * TB_FREQ_HZ / MS_PER_S * TICK, t_rel);
    check_time("mains_good_time", MAINS_GOOD_MS * TB_FREQ_HZ / MS_PER_S * TICK, t_mg);
    // Let the edge counters take in the final rise before they are compared.
    tick_wait(2);
    check("relay_rises", RELAY_PULSE_COUNT + 1, n_rel);
    check("mg_rises", MG_PULSE_COUNT + 1, n_mg);
    // Each half tick toggles once; the last edge may land either side of the stop.
    check_time("tb_toggles", 2 * MAINS_GOOD_MS * TB_FREQ_HZ / MS_PER_S - 2, n_tb);
    c0 = n_tb;
    tick_wait(100);
    check("tb_stopped", c0, n_tb);
    axi_rd(REG_STATUS);
    check("status_seq", 32'h3F, {26'h0, d[5:0]});
    check("irq_mg", 1, irq);
    axi_wr(REG_IRQ_STAT, 32'h1);
    tick_wait(2);
    check("irq_cleared", 0, irq);
    $display("test sequencer done");
    wait_pulse();
    wait_pulse();
    check("on_width", ON_PULSE_CYC, on_w);
    check("off_width", OFF_PULSE_CYC, off_w);
    check("late_starts", 0, late);
    wait_lvl(pwm_off, 1'b1);
    tick_wait(3);
    check("down_req_off", 1, down_prog_req);
    check("on_during_off", 0, pwm_on);
    wait_lvl(pwm_off, 1'b0);
    voltage_loop_low <= 1'b1;
    tick_wait(5);
    check("down_req_loop", 1, down_prog_req);
    voltage_loop_low <= 1'b0;
    tick_wait(5);
    check("down_req_idle", 0, down_prog_req);
    $display("test pulse shape done");
    for (int g = 0; g < 5; g++)
    begin
      wait_pulse();
      tick_wait(10 + $urandom % 50);
      set_gate(g, 1'b0);
      tick_wait(5);
      check("cut", 0, pwm_on);
      c0 = on_cnt;
      tick_wait(5200);
      check("held", c0, on_cnt);
      set_gate(g, 1'b1);
      if (g == 3)
      begin
        tick_wait(5200);
        check("latched", c0, on_cnt);
        protect_latch_clear_n <= 1'b0;
        tick_wait(4);
        protect_latch_clear_n <= 1'b1;
      end
    end
    wait_pulse();
    axi_rd(REG_IRQ_STAT);
    check("irq_stat", 4'h6, d[3:0]);
    check("irq_ovp", 1, irq);
    $display("test gating done");
    unregulated_bias <= 1'b0;
    tick_wait(5);
    check("relay_after_loss", 1, relay_drive_n);
    check("mg_after_loss", 0, line_loss_flag);
    check("on_after_loss", 0, pwm_on);
    unregulated_bias <= 1'b1;
    tick_wait(SLACK);
    check("relay_stage_restart", 1, relay_stage);
    check("mg_stage_restart", 1, mg_stage);
    check("mid_restart", 0, mid_stage);
    check_time("mid_clk_rises", n_osc / 8 - 1, n_mid);
    check_time("mod_clk_rises", n_osc / 16 - 1, n_mod);
    $display("test power cycle done");
    tally_and_finish();
  end
endmodule
